/* verilog/register_set_pkg.sv */
// Package: constants, field layouts and carrier types of the register set
package register_set_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int NUM_DATA_REGS = 8;
  localparam int NUM_BASE_REGS = 7;
  localparam int STACK_REG_INDEX = 7;
  localparam int FC_WIDTH = 3;

  // ----------------------------------------------------------------
  // Status word field positions
  // ----------------------------------------------------------------
  localparam int SR_FLOW_TRACE = 15;
  localparam int SR_INSTR_TRACE = 14;
  localparam int SR_SUPERVISOR = 13;
  localparam int SR_MASTER = 12;
  localparam int SR_MASK_HI = 10;
  localparam int SR_MASK_LO = 8;
  localparam int SR_EXTEND = 4;
  localparam int SR_NEGATIVE = 3;
  localparam int SR_ZERO = 2;
  localparam int SR_OVERFLOW = 1;
  localparam int SR_CARRY = 0;
  localparam logic [15:0] SR_IMPL_MASK = 16'hF71F;
  localparam logic [15:0] CCR_MASK = 16'h001F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] CACHE_RESET = 32'h0000_0000;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  localparam logic [2:0] FC_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Operand sizes, field operations, control register selects
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    size_byte = 2'h0,
    size_word = 2'h1,
    size_long = 2'h2
  } size_type;

  typedef enum logic [2:0] {
    field_test = 3'h0,
    field_extract_unsigned = 3'h1,
    field_extract_signed = 3'h2,
    field_find_first_one = 3'h3,
    field_invert = 3'h4,
    field_clear = 3'h5,
    field_set = 3'h6,
    field_insert = 3'h7
  } bf_op_type;

  typedef enum logic [2:0] {
    ctrl_vector_base = 3'h0,
    ctrl_src_fc = 3'h1,
    ctrl_dst_fc = 3'h2,
    ctrl_cache_addr = 3'h3,
    ctrl_cache_ctrl = 3'h4,
    ctrl_user_sp = 3'h5,
    ctrl_int_sp = 3'h6,
    ctrl_master_sp = 3'h7
  } ctrl_sel_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [3:0] sel;
    size_type size;
    logic [31:0] data;
  } gpr_write_type;

  typedef struct packed {
    logic en;
    logic [2:0] hi_sel;
    logic [2:0] lo_sel;
    logic [63:0] data;
  } quad_write_type;

  typedef struct packed {
    logic en;
    ctrl_sel_type sel;
    logic [31:0] data;
  } ctrl_write_type;

  typedef struct packed {
    logic en;
    bf_op_type op;
    logic mem;
    logic [2:0] src_sel;
    logic [2:0] dst_sel;
    logic [31:0] offset;
    logic [5:0] width;
    logic [31:0] insert;
    logic [63:0] window;
  } bf_req_type;

endpackage

/* verilog/bit_field_unit.sv */
// Combinational bit-field datapath: mask, extract, modify and find-first-one
`timescale 1ns/1ps
module bit_field_unit
  import register_set_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Operand window, field position and request
  input wire logic [2*WIDTH-1:0] src_in,
  input wire logic [4:0] offset_in,
  input wire logic [5:0] width_in,
  input wire logic [WIDTH-1:0] insert_in,
  input wire bf_op_type op_in,
  // Results
  output logic [2*WIDTH-1:0] modified_out,
  output logic [2*WIDTH-1:0] mask_out,
  output logic [WIDTH-1:0] value_out,
  output logic [5:0] pos_out,
  output logic neg_out,
  output logic zero_out
);

  logic [5:0] width_n;
  logic [5:0] rshift;
  logic [WIDTH-1:0] mask_left;
  logic [2*WIDTH-1:0] slice;
  logic [WIDTH-1:0] field_left;
  logic [2*WIDTH-1:0] ins_wide;

  // Width 0 or above 32 means a full 32-bit field
  assign width_n = (width_in == 6'h00 || width_in > 6'h20) ? 6'h20 : width_in;
  assign rshift = 6'h20 - width_n;
  assign mask_left = {WIDTH{1'b1}} << rshift[4:0];
  // Field may straddle the upper and lower words of the window
  assign mask_out = {mask_left, {WIDTH{1'b0}}} >> offset_in;
  assign slice = src_in << offset_in;
  assign field_left = slice[2*WIDTH-1:WIDTH] & mask_left;
  assign ins_wide = {insert_in << rshift[4:0], {WIDTH{1'b0}}} >> offset_in;
  // Flags taken from the field before any change
  assign neg_out = field_left[WIDTH-1];
  assign zero_out = (field_left == '0);

  // Right-justified value, zero or sign extended
  always_comb begin
    if (op_in == field_extract_signed) begin
      value_out = WIDTH'($signed(field_left) >>> rshift);
    end else begin
      value_out = field_left >> rshift;
    end
  end

  // First set bit counted from the field's top; none found gives the width
  always_comb begin
    pos_out = width_n;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (field_left[WIDTH-1-i]) begin
        pos_out = 6'(i);
      end
    end
  end

  // Modified window for the writing operations
  always_comb begin
    case (op_in)
      field_invert: modified_out = src_in ^ mask_out;
      field_clear: modified_out = src_in & ~mask_out;
      field_set: modified_out = src_in | mask_out;
      field_insert: modified_out = (src_in & ~mask_out) | (ins_wide & mask_out);
      default: modified_out = src_in;
    endcase
  end

endmodule // bit_field_unit

/* verilog/register_set_bitfield_unit.sv */
// Programmer-visible register set of the core with its bit-field datapath
`timescale 1ns/1ps
module register_set_bitfield_unit
  import register_set_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // General register write and read ports
  input wire gpr_write_type gpr_wr_in,
  input wire quad_write_type quad_wr_in,
  input wire logic [3:0] rd_a_sel_in,
  input wire logic [3:0] rd_b_sel_in,
  // Index register port
  input wire logic [3:0] index_sel_in,
  input wire logic index_word_in,
  input wire logic [1:0] index_scale_in,
  // Status word and condition codes
  input wire logic sr_wr_en_in,
  input wire logic [15:0] sr_wr_data_in,
  input wire logic ccr_wr_en_in,
  input wire logic [4:0] ccr_wr_data_in,
  // Program counter and control registers
  input wire logic pc_wr_en_in,
  input wire logic [31:0] pc_wr_data_in,
  input wire ctrl_write_type ctrl_wr_in,
  input wire ctrl_sel_type ctrl_rd_sel_in,
  // Instruction retirement for tracing
  input wire logic retire_in,
  input wire logic retire_flow_in,
  // Bit-field request
  input wire bf_req_type bf_req_in,
  // Register read data
  output logic [31:0] rd_a_out,
  output logic [31:0] rd_b_out,
  output logic [31:0] index_out,
  output logic [31:0] ctrl_rd_out,
  // Machine state
  output logic [15:0] sr_out,
  output logic [31:0] pc_out,
  output logic [31:0] vbr_out,
  output logic [31:0] stack_ptr_out,
  output logic trace_trap_out,
  // Bit-field answer
  output logic bf_done_out,
  output logic [31:0] bf_result_out,
  output logic [63:0] bf_window_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] data_regs_q [NUM_DATA_REGS];
  logic [31:0] base_address_regs_q [NUM_BASE_REGS];
  logic [31:0] user_sp_q;
  logic [31:0] int_sp_q;
  logic [31:0] master_sp_q;
  logic [15:0] sr_q;
  logic [31:0] pc_q;
  logic [31:0] vbr_q;
  logic [2:0] src_fc_q;
  logic [2:0] dst_fc_q;
  logic [31:0] cache_addr_q;
  logic [31:0] cache_ctrl_q;
  logic [31:0] rd_a_q;
  logic [31:0] rd_b_q;
  logic [31:0] index_q;
  logic [31:0] ctrl_rd_q;
  logic [31:0] stack_ptr_q;
  logic trace_trap_q;
  logic bf_done_q;
  logic [31:0] bf_result_q;
  logic [63:0] bf_window_q;

  // ----------------------------------------------------------------
  // Stack pointer selection
  // ----------------------------------------------------------------
  logic supervisor;
  logic master;
  logic [31:0] active_sp;

  assign supervisor = sr_q[SR_SUPERVISOR];
  assign master = sr_q[SR_MASTER];

  // Register 7 of the address bank is whichever stack pointer is live
  always_comb begin
    if (!supervisor) begin
      active_sp = user_sp_q;
    end else if (master) begin
      active_sp = master_sp_q;
    end else begin
      active_sp = int_sp_q;
    end
  end

  // Read any of the sixteen general registers
  function automatic logic [31:0] read_gpr(input logic [3:0] sel);
    logic [31:0] value;
    value = GPR_RESET;
    if (!sel[3]) begin
      value = data_regs_q[sel[2:0]];
    end else if (sel[2:0] == 3'(STACK_REG_INDEX)) begin
      value = active_sp;
    end else begin
      value = base_address_regs_q[sel[2:0]];
    end
    return value;
  endfunction

  // ----------------------------------------------------------------
  // Bit-field datapath
  // ----------------------------------------------------------------
  logic [31:0] bf_src_reg;
  logic [63:0] bf_src;
  logic [4:0] bf_offset;
  logic [63:0] bf_modified;
  logic [63:0] bf_mask;
  logic [31:0] bf_value;
  logic [5:0] bf_pos;
  logic bf_neg;
  logic bf_zero;

  // Register operand wraps around, so it is doubled into the window
  assign bf_src_reg = data_regs_q[bf_req_in.src_sel];
  assign bf_src = bf_req_in.mem ? bf_req_in.window : {bf_src_reg, bf_src_reg};
  // Memory window starts at the byte holding the field's first bit
  assign bf_offset = bf_req_in.mem ? {2'h0, bf_req_in.offset[2:0]} : bf_req_in.offset[4:0];

  bit_field_unit #(
    .WIDTH(XLEN)
  ) u_bit_field_unit (
    .src_in(bf_src),
    .offset_in(bf_offset),
    .width_in(bf_req_in.width),
    .insert_in(bf_req_in.insert),
    .op_in(bf_req_in.op),
    .modified_out(bf_modified),
    .mask_out(bf_mask),
    .value_out(bf_value),
    .pos_out(bf_pos),
    .neg_out(bf_neg),
    .zero_out(bf_zero)
  );

  // Write-back decision for a register-sourced or result-producing op
  logic bf_modifies;
  logic bf_returns;
  logic bf_wb_en;
  logic [2:0] bf_wb_sel;
  logic [31:0] bf_wb_data;
  logic [31:0] bf_merged;
  logic [31:0] bf_answer;

  assign bf_modifies = bf_req_in.op inside {field_invert, field_clear, field_set, field_insert};
  assign bf_returns = bf_req_in.op inside {field_extract_unsigned, field_extract_signed,
                                           field_find_first_one};
  // Merge both halves of the wrapped window back into one register
  assign bf_merged = (bf_src_reg & ~(bf_mask[63:32] | bf_mask[31:0]))
                   | (bf_modified[63:32] & bf_mask[63:32])
                   | (bf_modified[31:0] & bf_mask[31:0]);

  // Find-first-one answers with an absolute bit offset
  always_comb begin
    if (bf_req_in.op == field_find_first_one) begin
      bf_answer = bf_req_in.offset + {26'h0, bf_pos};
    end else begin
      bf_answer = bf_value;
    end
  end

  // Write port for the data bank driven by the field unit
  always_comb begin
    bf_wb_en = 1'b0;
    bf_wb_sel = bf_req_in.dst_sel;
    bf_wb_data = bf_answer;
    if (bf_req_in.en) begin
      if (bf_returns) begin
        bf_wb_en = 1'b1;
      end else if (bf_modifies && !bf_req_in.mem) begin
        bf_wb_en = 1'b1;
        bf_wb_sel = bf_req_in.src_sel;
        bf_wb_data = bf_merged;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // Later writes win: field write-back beats quad beats plain write
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      for (int i = 0; i < NUM_DATA_REGS; i++) begin
        data_regs_q[i] <= GPR_RESET;
      end
    end else begin
      if (gpr_wr_in.en && !gpr_wr_in.sel[3]) begin
        case (gpr_wr_in.size)
          size_byte: data_regs_q[gpr_wr_in.sel[2:0]][7:0] <= gpr_wr_in.data[7:0];
          size_word: data_regs_q[gpr_wr_in.sel[2:0]][15:0] <= gpr_wr_in.data[15:0];
          default: data_regs_q[gpr_wr_in.sel[2:0]] <= gpr_wr_in.data;
        endcase
      end
      if (quad_wr_in.en) begin
        data_regs_q[quad_wr_in.hi_sel] <= quad_wr_in.data[63:32];
        data_regs_q[quad_wr_in.lo_sel] <= quad_wr_in.data[31:0];
      end
      if (bf_wb_en) begin
        data_regs_q[bf_wb_sel] <= bf_wb_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address registers and stack pointers
  // ----------------------------------------------------------------
  logic [31:0] addr_wr_data;
  logic addr_wr;
  logic sp_wr;

  // Word writes to an address register sign extend to the full width
  assign addr_wr_data = (gpr_wr_in.size == size_long) ? gpr_wr_in.data
                      : {{16{gpr_wr_in.data[15]}}, gpr_wr_in.data[15:0]};
  assign addr_wr = gpr_wr_in.en && gpr_wr_in.sel[3];
  assign sp_wr = addr_wr && (gpr_wr_in.sel[2:0] == 3'(STACK_REG_INDEX));

  // Base address registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      for (int i = 0; i < NUM_BASE_REGS; i++) begin
        base_address_regs_q[i] <= GPR_RESET;
      end
    end else if (addr_wr && !sp_wr) begin
      base_address_regs_q[gpr_wr_in.sel[2:0]] <= addr_wr_data;
    end
  end

  // Stack pointers: direct control writes take priority over register 7
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      user_sp_q <= GPR_RESET;
      int_sp_q <= GPR_RESET;
      master_sp_q <= GPR_RESET;
    end else begin
      if (sp_wr) begin
        if (!supervisor) begin
          user_sp_q <= addr_wr_data;
        end else if (master) begin
          master_sp_q <= addr_wr_data;
        end else begin
          int_sp_q <= addr_wr_data;
        end
      end
      if (ctrl_wr_in.en) begin
        case (ctrl_wr_in.sel)
          ctrl_user_sp: user_sp_q <= ctrl_wr_in.data;
          ctrl_int_sp: int_sp_q <= ctrl_wr_in.data;
          ctrl_master_sp: master_sp_q <= ctrl_wr_in.data;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Field ops update flags last so they win over a same-cycle CCR write
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sr_q <= SR_RESET;
    end else begin
      if (sr_wr_en_in) begin
        sr_q <= sr_wr_data_in & SR_IMPL_MASK;
      end else if (ccr_wr_en_in) begin
        sr_q[4:0] <= ccr_wr_data_in;
      end
      if (bf_req_in.en) begin
        sr_q[SR_NEGATIVE] <= bf_neg;
        sr_q[SR_ZERO] <= bf_zero;
        sr_q[SR_OVERFLOW] <= 1'b0;
        sr_q[SR_CARRY] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trace trap
  // ----------------------------------------------------------------
  // One-cycle request to the exception logic after a retired instruction
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      trace_trap_q <= 1'b0;
    end else begin
      trace_trap_q <= retire_in && (sr_q[SR_INSTR_TRACE]
                      || (sr_q[SR_FLOW_TRACE] && retire_flow_in));
    end
  end

  // ----------------------------------------------------------------
  // Program counter and control registers
  // ----------------------------------------------------------------
  // Program counter
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pc_q <= PC_RESET;
    end else if (pc_wr_en_in) begin
      pc_q <= pc_wr_data_in;
    end
  end

  // Vector base, function codes and cache registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      vbr_q <= VBR_RESET;
      src_fc_q <= FC_RESET;
      dst_fc_q <= FC_RESET;
      cache_addr_q <= CACHE_RESET;
      cache_ctrl_q <= CACHE_RESET;
    end else if (ctrl_wr_in.en) begin
      case (ctrl_wr_in.sel)
        ctrl_vector_base: vbr_q <= ctrl_wr_in.data;
        ctrl_src_fc: src_fc_q <= ctrl_wr_in.data[FC_WIDTH-1:0];
        ctrl_dst_fc: dst_fc_q <= ctrl_wr_in.data[FC_WIDTH-1:0];
        ctrl_cache_addr: cache_addr_q <= ctrl_wr_in.data;
        ctrl_cache_ctrl: cache_ctrl_q <= ctrl_wr_in.data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  logic [31:0] index_raw;
  logic [31:0] index_ext;

  // Word-sized index is sign extended before scaling
  // Process, not assign: the function reads the banks
  always_comb begin
    index_raw = read_gpr(index_sel_in);
  end
  assign index_ext = index_word_in ? {{16{index_raw[15]}}, index_raw[15:0]} : index_raw;

  // Registered reads show the value before any same-cycle write
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rd_a_q <= GPR_RESET;
      rd_b_q <= GPR_RESET;
      index_q <= GPR_RESET;
      stack_ptr_q <= GPR_RESET;
    end else begin
      rd_a_q <= read_gpr(rd_a_sel_in);
      rd_b_q <= read_gpr(rd_b_sel_in);
      index_q <= index_ext << index_scale_in;
      stack_ptr_q <= active_sp;
    end
  end

  // Control register read mux
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl_rd_q <= GPR_RESET;
    end else begin
      case (ctrl_rd_sel_in)
        ctrl_vector_base: ctrl_rd_q <= vbr_q;
        ctrl_src_fc: ctrl_rd_q <= {29'h0, src_fc_q};
        ctrl_dst_fc: ctrl_rd_q <= {29'h0, dst_fc_q};
        ctrl_cache_addr: ctrl_rd_q <= cache_addr_q;
        ctrl_cache_ctrl: ctrl_rd_q <= cache_ctrl_q;
        ctrl_user_sp: ctrl_rd_q <= user_sp_q;
        ctrl_int_sp: ctrl_rd_q <= int_sp_q;
        ctrl_master_sp: ctrl_rd_q <= master_sp_q;
        default: ctrl_rd_q <= GPR_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit-field answer
  // ----------------------------------------------------------------
  // Memory operands come back as a modified window for the bus to store
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bf_done_q <= 1'b0;
      bf_result_q <= GPR_RESET;
      bf_window_q <= {GPR_RESET, GPR_RESET};
    end else begin
      bf_done_q <= bf_req_in.en;
      if (bf_req_in.en) begin
        bf_result_q <= bf_answer;
        bf_window_q <= bf_req_in.mem ? bf_modified : {bf_merged, bf_merged};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_a_out = rd_a_q;
  assign rd_b_out = rd_b_q;
  assign index_out = index_q;
  assign ctrl_rd_out = ctrl_rd_q;
  assign sr_out = sr_q;
  assign pc_out = pc_q;
  assign vbr_out = vbr_q;
  assign stack_ptr_out = stack_ptr_q;
  assign trace_trap_out = trace_trap_q;
  assign bf_done_out = bf_done_q;
  assign bf_result_out = bf_result_q;
  assign bf_window_out = bf_window_q;

endmodule // register_set_bitfield_unit

/* bench/reg_set_chk_sva.sv */
// Checker: timing relations of the register set ports
`timescale 1ns/1ps
module reg_set_chk
  import register_set_pkg::*;
(
  // Clock, reset and requests
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic sr_wr_en_in,
  input wire logic [15:0] sr_wr_data_in,
  input wire ctrl_write_type ctrl_wr_in,
  input wire logic retire_in,
  input wire logic retire_flow_in,
  input wire bf_req_type bf_req_in,
  // Watched outputs
  input wire logic [15:0] sr_out,
  input wire logic [31:0] vbr_out,
  input wire logic trace_trap_out,
  input wire logic bf_done_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // ------------------------------------------------------------
  // Trace, status word, field ops, vector base
  // ------------------------------------------------------------
  AST_TRACE_ALL: assert property (retire_in && sr_out[14] |=> trace_trap_out) else $error("missing trap");
  AST_TRACE_FLOW: assert property (retire_in && retire_flow_in && sr_out[15] |=> trace_trap_out)
    else $error("missing flow trap");
  AST_TRACE_SKIP: assert property (retire_in && !retire_flow_in && sr_out[15:14] == 2'b10 |=> !trace_trap_out)
    else $error("spurious trap");
  // Reset value checked while reset itself is high
  AST_SR_RESET: assert property (disable iff (1'b0) srst_in |=> sr_out == SR_RESET) else $error("bad reset");
  AST_SR_WRITE: assert property (sr_wr_en_in && !bf_req_in.en
    |=> sr_out == ($past(sr_wr_data_in) & SR_IMPL_MASK)) else $error("bad status write");
  AST_BF_DONE: assert property (bf_req_in.en ##1 !bf_req_in.en |-> bf_done_out ##1 !bf_done_out)
    else $error("bad done pulse");
  AST_BF_VC: assert property (bf_req_in.en && !sr_wr_en_in |=> sr_out[1:0] == 2'b00) else $error("V C set");
  AST_VBR: assert property (ctrl_wr_in.en && ctrl_wr_in.sel == ctrl_vector_base
    |=> vbr_out == $past(ctrl_wr_in.data)) else $error("bad vbr");
endmodule // reg_set_chk

bind register_set_bitfield_unit reg_set_chk u_chk (.clock_in(clock_in), .srst_in(srst_in),
  .sr_wr_en_in(sr_wr_en_in), .sr_wr_data_in(sr_wr_data_in), .ctrl_wr_in(ctrl_wr_in), .retire_in(retire_in),
  .retire_flow_in(retire_flow_in), .bf_req_in(bf_req_in), .sr_out(sr_out), .vbr_out(vbr_out),
  .trace_trap_out(trace_trap_out), .bf_done_out(bf_done_out));

/* bench/tb.sv */
// Testbench: self-checking run of the register set and bit-field unit
`timescale 1ns/1ps
module tb;
  import register_set_pkg::*;
  logic clock_in, srst_in, sr_wr_en_in, ccr_wr_en_in, pc_wr_en_in, retire_in, retire_flow_in, trace_trap_out;
  logic bf_done_out;
  logic [63:0] bf_window_out;
  logic [3:0] rd_a_sel_in, rd_b_sel_in, index_sel_in;
  logic [15:0] sr_wr_data_in, sr_out;
  logic [4:0] ccr_wr_data_in;
  logic [31:0] pc_wr_data_in, rd_a_out, rd_b_out, index_out, ctrl_rd_out, pc_out, vbr_out, bf_result_out;
  gpr_write_type gpr_wr_in;
  ctrl_write_type ctrl_wr_in;
  ctrl_sel_type ctrl_rd_sel_in;
  bf_req_type bf_req_in;
  int err_count, samples_checked, o, w, opc;
  logic [31:0] lfsr_q, model [16], v, f, e, ins, stack_ptr_out;
  register_set_bitfield_unit dut (.clock_in(clock_in), .srst_in(srst_in), .gpr_wr_in(gpr_wr_in),
    .quad_wr_in('0), .rd_a_sel_in(rd_a_sel_in), .rd_b_sel_in(rd_b_sel_in), .index_sel_in(index_sel_in),
    .index_word_in(1'b0), .index_scale_in(2'h0), .sr_wr_en_in(sr_wr_en_in), .sr_wr_data_in(sr_wr_data_in),
    .ccr_wr_en_in(ccr_wr_en_in), .ccr_wr_data_in(ccr_wr_data_in), .pc_wr_en_in(pc_wr_en_in),
    .pc_wr_data_in(pc_wr_data_in), .ctrl_wr_in(ctrl_wr_in), .ctrl_rd_sel_in(ctrl_rd_sel_in),
    .retire_in(retire_in), .retire_flow_in(retire_flow_in), .bf_req_in(bf_req_in), .rd_a_out(rd_a_out),
    .rd_b_out(rd_b_out), .index_out(index_out), .ctrl_rd_out(ctrl_rd_out), .sr_out(sr_out), .pc_out(pc_out),
    .vbr_out(vbr_out), .stack_ptr_out(stack_ptr_out), .trace_trap_out(trace_trap_out), .bf_done_out(bf_done_out),
    .bf_result_out(bf_result_out), .bf_window_out(bf_window_out));
  // ------------------------------------------------------------
  // Helpers: stimulus source, compares, field model
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  function automatic logic [31:0] rnd();
    lfsr_q = lfsr_q[0] ? (lfsr_q >> 1) ^ 32'hA3000000 : lfsr_q >> 1;
    return lfsr_q;
  endfunction
  task automatic cyc();
    @(negedge clock_in);
  endtask
  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, x, g);
    end
  endtask
  task automatic chk_flag(input logic x, input logic g);
    chk({31'h0, x}, {31'h0, g});
  endtask
  task automatic wr_gpr(input logic [3:0] s, input size_type z, input logic [31:0] d);
    gpr_wr_in = '{en: 1'b1, sel: s, size: z, data: d};
    cyc(); // Caller lowers en after the last write
  endtask
  task automatic wr_sr(input logic [15:0] d);
    sr_wr_en_in = 1'b1;
    sr_wr_data_in = d;
    cyc();
    sr_wr_en_in = 1'b0;
  endtask
  // Bit zero of a field is the register MSB, so offsets wrap at 32
  function automatic logic [31:0] fld(input logic [31:0] x, input int o, input int w);
    fld = 32'h0;
    for (int k = 0; k < w; k++) fld = {fld[30:0], x[31 - (o + k) % 32]};
  endfunction
  function automatic logic [31:0] mdf(input logic [31:0] x, int o, int w, int op, logic [31:0] d);
    int p;
    for (int k = 0; k < w; k++) begin
      p = 31 - (o + k) % 32;
      x[p] = op == 4 ? ~x[p] : op == 5 ? 1'b0 : op == 6 ? 1'b1 : d[w - 1 - k];
    end
    return x;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well past the hundred or so cycles the run needs
  initial begin
    #16000;
    err_count++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {sr_wr_en_in, ccr_wr_en_in, pc_wr_en_in, retire_in, retire_flow_in} = '0;
    {rd_a_sel_in, rd_b_sel_in, index_sel_in, sr_wr_data_in, ccr_wr_data_in, pc_wr_data_in} = '0;
    gpr_wr_in = '0;
    ctrl_wr_in = '0;
    bf_req_in = '0;
    ctrl_rd_sel_in = ctrl_vector_base;
    lfsr_q = 32'h000039F1;
    srst_in = 1'b1;
    repeat (7) cyc();
    srst_in = 1'b0;
    chk({16'h0, SR_RESET}, {16'h0, sr_out});
    // All sixteen registers, reg 15 being the live interrupt stack
    for (int i = 0; i < 16; i++) begin
      model[i] = rnd();
      wr_gpr(4'(i), size_long, model[i]);
    end
    wr_gpr(4'h9, size_word, 32'h12348001);
    model[9] = 32'hFFFF8001;
    wr_gpr(4'h2, size_byte, 32'h000000A5);
    model[2][7:0] = 8'hA5;
    gpr_wr_in.en = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd_a_sel_in = 4'(i);
      rd_b_sel_in = 4'(15 - i);
      index_sel_in = 4'(i);
      cyc();
      chk(model[i], rd_a_out);
      chk(model[15 - i], rd_b_out);
      chk(model[i], index_out);
      chk(model[15], stack_ptr_out);
    end
    $display("register test done");
    // Control registers and program counter
    for (int c = 0; c < 8; c++) begin
      v = rnd();
      ctrl_wr_in = '{en: 1'b1, sel: ctrl_sel_type'(c), data: v};
      ctrl_rd_sel_in = ctrl_sel_type'(c);
      cyc();
      ctrl_wr_in.en = 1'b0;
      cyc();
      chk((c == 1 || c == 2) ? {29'h0, v[2:0]} : v, ctrl_rd_out);
      if (c == 0) chk(v, vbr_out);
    end
    v = rnd();
    pc_wr_en_in = 1'b1;
    pc_wr_data_in = v;
    cyc();
    pc_wr_en_in = 1'b0;
    chk(v, pc_out);
    $display("control test done");
    // Every field op, the last one an empty field search
    for (int op = 0; op < 9; op++) begin
      opc = op == 8 ? 3 : op;
      o = rnd() % 32;
      w = rnd() % 32 + 1;
      ins = rnd();
      v = op == 8 ? 32'h0 : rnd();
      wr_gpr(4'h0, size_long, v);
      gpr_wr_in.en = 1'b0;
      f = fld(v, o, w);
      e = opc == 2 && f[w - 1] ? f | (~32'h0 << w) : f;
      if (opc == 3) begin
        e = o + w;
        for (int k = 0; k < w; k++) if (f[k]) e = o + w - 1 - k;
      end
      bf_req_in = '{en: 1'b1, op: bf_op_type'(opc), mem: 1'b0, src_sel: 3'h0, dst_sel: 3'h1, offset: o,
        width: 6'(w), insert: ins, window: 64'h0};
      rd_a_sel_in = 4'h0;
      rd_b_sel_in = 4'h1;
      cyc();
      bf_req_in.en = 1'b0;
      chk_flag(1'b1, bf_done_out);
      chk_flag(f[w - 1], sr_out[SR_NEGATIVE]);
      chk_flag(f == 32'h0, sr_out[SR_ZERO]);
      if (opc >= 1 && opc <= 3) begin
        chk(e, bf_result_out);
        model[1] = e;
      end
      cyc();
      if (opc >= 4) v = mdf(v, o, w, opc, ins);
      chk(v, rd_a_out);
      chk(v, bf_window_out[63:32]);
      chk(model[1], rd_b_out);
    end
    $display("field test done");
    // Status word fields, then trace traps
    wr_sr(16'hFFFF);
    chk({16'h0, SR_IMPL_MASK}, {16'h0, sr_out});
    ccr_wr_en_in = 1'b1;
    ccr_wr_data_in = 5'h15;
    cyc();
    ccr_wr_en_in = 1'b0;
    chk(32'h15, {27'h0, sr_out[4:0]});
    for (int i = 0; i < 4; i++) begin
      wr_sr(i == 0 ? 16'h4000 : i == 3 ? 16'h0000 : 16'h8000);
      retire_in = 1'b1;
      retire_flow_in = i >= 2;
      cyc();
      retire_in = 1'b0;
      chk_flag(i == 0 || i == 2, trace_trap_out);
      cyc();
      chk_flag(1'b0, trace_trap_out);
    end
    $display("trace test done");
    finish_test();
  end
endmodule // tb
